/* hw/blc_pkg.sv */
package blc_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_BRIGHTNESS = 8'h00;
   localparam logic [7:0] ADDR_CONTROL = 8'h01;
   localparam logic [7:0] ADDR_STATUS = 8'h02;
   localparam logic [7:0] ADDR_IDENTITY = 8'h03;
   localparam logic [7:0] ADDR_DC_LEVEL = 8'h07;
   localparam logic [7:0] ADDR_OPTIONS = 8'h08;

   // ----------------------------------------
   // Values after reset
   // ----------------------------------------
   localparam logic [7:0] RESET_BRIGHTNESS = 8'hFF;
   localparam logic [7:0] RESET_CONTROL = 8'h00;
   localparam logic [7:0] RESET_DC_LEVEL = 8'hFF;
   localparam logic [7:0] RESET_OPTIONS = 8'h1F;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTL_ON_BIT = 0;
   localparam int CTL_SEL_BIT = 1;
   localparam int CTL_MODE_BIT = 2;
   localparam int ST_FAULT_BIT = 0;
   localparam int OPT_VSC_LSB = 0;
   localparam int OPT_FSW_BIT = 2;
   localparam int OPT_DRIVE_LSB = 3;
   localparam int OPT_DUTY_BIT = 5;
   localparam int OPT_PASS_BIT = 6;
   localparam logic ID_MARK = 1'b1;

   // ----------------------------------------
   // Channels
   // ----------------------------------------
   localparam int CHANNEL_COUNT = 6;
   localparam logic [5:0] CHANNEL_MASK = 6'h3F;
   localparam logic [5:0] CHANNEL_NONE = 6'h00;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_FREQ_HZ = 100000000;
   localparam int BL_ON_TIME_MS = 4;
   localparam int BL_ON_MAX_CYCLES = BL_ON_TIME_MS * (CLK_FREQ_HZ / 1000);
   localparam int ON_COUNT_WIDTH = 19;
   localparam logic [7:0] WINDOW_LAST = 8'hFF;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      DIM_COMBINED = 2'b00,
      DIM_PWM_PIN = 2'b01,
      DIM_HOST_ONLY = 2'b10,
      DIM_KEEP = 2'b11
   } blc_dim_t;

   typedef enum logic [1:0] {
      BL_OFF = 2'b00,
      BL_STARTING = 2'b01,
      BL_ON = 2'b10
   } blc_state_t;

endpackage

/* hw/blc_regs.sv */
// Notes on behaviour
// RULE1 - On request bit at 0 keeps backlight off whatever the dimming bits say.
// RULE2 - When on, select bits pick combined, pin PWM, host-only, or keep mode.
// RULE3 - Turning on with both select bits 1 keeps the earlier dimming mode.
// RULE4 - Reserved control bits read 0 until written, then return written value.
// RULE5 - Every defined control bit reads back its latched value.
// RULE6 - Writing on request 1 brings backlight on within 4 ms.
// RULE7 - Writing on request 0 turns backlight off immediately, channels to zero.
// RULE8 - Brightness register reads back last host write in combined mode.
// RULE9 - Fault summary is OR of thermal, overcurrent, channel-down flags only.
// RULE10 - One-channel-down flag reads 1 when any channel has faulted out.
// RULE11 - Two-channels-down flag reads 1 when two or more channels faulted.
// RULE12 - Fault summary stays set after its cause goes away.
// RULE13 - Toggling on request or writing 0 to summary clears it.
// RULE14 - Summary sets again if the fault persists or recurs after clearing.
// RULE15 - Quick on then off command never reports a fault.
// RULE16 - Status reserved bits read 0; only summary bit is writable.
// RULE17 - Backlight-on flag reads 1 while on, 0 while off.
// RULE18 - Identity holds a read-only 3-bit silicon revision in low bits.
// RULE19 - Revision starts at 0 and steps by 1 per released part.
// RULE20 - Identity bit 7 reads 1, bits 6 to 3 hold fixed maker code.
// RULE21 - DC level sets current linearly in 256 steps, live; reads return it.
// RULE22 - DC level writes leave PWM brightness untouched.
// RULE23 - Pass-through option makes channel current follow PWM input directly.
// RULE24 - Duty-to-current keeps sources on with DC level from input duty.
// RULE25 - Host picks one of four boost drive strengths by 2-bit field.
// RULE26 - Drive codes 00..11 mean 25, 50, 75, 100 percent.
// RULE27 - Frequency bit 0 selects 1.2 MHz, 1 selects 600 kHz.
// RULE28 - Short threshold 0 disables, 1..3 select 3.6, 4.8, 5.8 V.
// RULE29 - Writes to read-only status and identity bits change nothing.
`timescale 1ns/10ps

module blc_regs
   import blc_pkg::*;
#(
   parameter int unsigned ON_DELAY_CYCLES = BL_ON_MAX_CYCLES,
   parameter logic [3:0] MAKER_CODE = 4'hF, // Arbitrary value
   parameter logic [2:0] SILICON_REV = 3'h0
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register access port
   input wire logic [7:0] hostAddr,
   input wire logic [7:0] hostWrData,
   input wire logic hostWrite,
   input wire logic hostRead,
   output logic [7:0] hostRdData,
   output logic hostRdValid,
   // Fault and PWM pins
   input wire logic thermalTripPin,
   input wire logic inputOvercurrentPin,
   input wire logic [5:0] channelFaultPin,
   input wire logic pwmInputPin,
   // Driver controls
   output logic [5:0] channelsActive,
   output logic ledGate,
   output logic [7:0] currentLevel,
   output logic [1:0] dimmingMode,
   output logic [1:0] switchDriveStrength,
   output logic switchFrequencySelect,
   output logic [1:0] shortThreshold
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [8:0] pinMeta;
   logic [8:0] pinSync;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         pinMeta <= 9'h000;
         pinSync <= 9'h000;
      end
      else
      begin
         pinMeta <= {pwmInputPin, channelFaultPin, inputOvercurrentPin, thermalTripPin};
         pinSync <= pinMeta;
      end
   end

   // ----------------------------------------
   // Channel fault count
   // ----------------------------------------
   function automatic logic [2:0] countDown(input logic [5:0] faults);
      logic [2:0] total;
      total = 3'h0;
      for (int i = 0; i < CHANNEL_COUNT; i++)
      begin
         total = total + {2'b00, faults[i]};
      end
      return total;
   endfunction

   logic thermalTripFlag;
   logic inputOvercurrentFlag;
   logic oneChannelDownFlag;
   logic twoChannelsDownFlag;
   logic pwmInSync;
   logic [2:0] downCount;

   assign thermalTripFlag = pinSync[0];
   assign inputOvercurrentFlag = pinSync[1];
   assign pwmInSync = pinSync[8];
   assign downCount = countDown(pinSync[7:2]);
   assign oneChannelDownFlag = (downCount >= 3'h1); // RULE10
   assign twoChannelsDownFlag = (downCount >= 3'h2); // RULE11

   // ----------------------------------------
   // Registers and backlight sequencing
   // ----------------------------------------
   logic [7:0] backlightControl;
   logic [7:0] pwmBrightness;
   logic [7:0] dcCurrentLevel;
   logic [7:0] driverOptions;
   logic faultSummary;
   blc_dim_t dimMode;
   blc_state_t blState;
   logic [ON_COUNT_WIDTH-1:0] onCount;
   logic [7:0] pwmCount;
   logic [7:0] highCount;
   logic [7:0] measuredDuty;

   logic [7:0] next_backlightControl;
   logic [7:0] next_pwmBrightness;
   logic [7:0] next_dcCurrentLevel;
   logic [7:0] next_driverOptions;
   logic next_faultSummary;
   blc_dim_t next_dimMode;
   blc_state_t next_blState;
   logic [ON_COUNT_WIDTH-1:0] next_onCount;
   logic [7:0] next_pwmCount;
   logic [7:0] next_highCount;
   logic [7:0] next_measuredDuty;
   logic [7:0] next_hostRdData;
   logic next_hostRdValid;
   logic [5:0] next_channelsActive;
   logic next_ledGate;
   logic [7:0] next_currentLevel;

   logic writeControl;
   logic requestNow;
   logic requestToggled;
   logic clearFault;
   logic faultCause;
   logic backlightOnFlag;
   logic hostPwmGate;
   logic dimGate;
   logic [7:0] statusByte;
   logic [7:0] identityByte;

   always_comb
   begin
      next_backlightControl = backlightControl;
      next_pwmBrightness = pwmBrightness;
      next_dcCurrentLevel = dcCurrentLevel;
      next_driverOptions = driverOptions;
      next_dimMode = dimMode;
      next_blState = blState;
      next_onCount = onCount;
      next_hostRdData = hostRdData;
      next_hostRdValid = hostRead;
      backlightOnFlag = (blState == BL_ON); // RULE17

      // Control writes; reserved bits are stored as written
      writeControl = hostWrite && (hostAddr == ADDR_CONTROL);
      requestNow = writeControl ? hostWrData[CTL_ON_BIT] : backlightControl[CTL_ON_BIT];
      requestToggled = writeControl && (hostWrData[CTL_ON_BIT] != backlightControl[CTL_ON_BIT]);
      if (writeControl)
      begin
         next_backlightControl = hostWrData; // RULE4 RULE5
      end
      if (writeControl && hostWrData[CTL_ON_BIT]
         && (hostWrData[CTL_MODE_BIT:CTL_SEL_BIT] != DIM_KEEP)) // RULE3
      begin
         next_dimMode = blc_dim_t'(hostWrData[CTL_MODE_BIT:CTL_SEL_BIT]); // RULE2
      end
      if (hostWrite && (hostAddr == ADDR_BRIGHTNESS) && (dimMode != DIM_PWM_PIN))
      begin
         next_pwmBrightness = hostWrData; // RULE8
      end
      if (hostWrite && (hostAddr == ADDR_DC_LEVEL))
      begin
         next_dcCurrentLevel = hostWrData; // RULE21 RULE22
      end
      if (hostWrite && (hostAddr == ADDR_OPTIONS))
      begin
         next_driverOptions = hostWrData;
      end

      // Backlight sequencing
      unique case (blState)
         BL_OFF:
         begin
            if (requestNow)
            begin
               next_blState = BL_STARTING;
               next_onCount = ON_DELAY_CYCLES[ON_COUNT_WIDTH-1:0];
            end
         end
         BL_STARTING:
         begin
            if (!requestNow)
            begin
               next_blState = BL_OFF; // RULE7
            end
            else if (onCount <= {{(ON_COUNT_WIDTH-1){1'b0}}, 1'b1})
            begin
               next_blState = BL_ON; // RULE6
            end
            else
            begin
               next_onCount = onCount - {{(ON_COUNT_WIDTH-1){1'b0}}, 1'b1};
            end
         end
         BL_ON:
         begin
            if (!requestNow)
            begin
               next_blState = BL_OFF; // RULE1 RULE7
            end
         end
         default:
         begin
            next_blState = BL_OFF;
         end
      endcase

      // Sticky fault summary; a new cause wins over a clear
      faultCause = thermalTripFlag || inputOvercurrentFlag
         || oneChannelDownFlag || twoChannelsDownFlag; // RULE9
      clearFault = requestToggled
         || (hostWrite && (hostAddr == ADDR_STATUS) && !hostWrData[ST_FAULT_BIT]); // RULE13 RULE16 RULE29
      next_faultSummary = (faultSummary && !clearFault) // RULE12
         || (faultCause && backlightOnFlag); // RULE14 RULE15

      // Dimming counter and input duty measurement
      next_pwmCount = pwmCount + 8'h01;
      if (pwmCount == WINDOW_LAST)
      begin
         next_measuredDuty = highCount;
         next_highCount = 8'h00;
      end
      else
      begin
         next_measuredDuty = measuredDuty;
         next_highCount = highCount + {7'h00, pwmInSync};
      end
      hostPwmGate = (pwmCount < pwmBrightness);
      unique case (dimMode)
         DIM_COMBINED: dimGate = hostPwmGate && pwmInSync;
         DIM_PWM_PIN: dimGate = pwmInSync;
         DIM_HOST_ONLY: dimGate = hostPwmGate;
         default: dimGate = hostPwmGate;
      endcase

      // Driver outputs
      next_channelsActive = (next_blState == BL_ON) ? CHANNEL_MASK : CHANNEL_NONE; // RULE1 RULE6 RULE7
      if (next_blState != BL_ON)
      begin
         next_ledGate = 1'b0; // RULE1
      end
      else if (driverOptions[OPT_PASS_BIT])
      begin
         next_ledGate = pwmInSync; // RULE23
      end
      else if (driverOptions[OPT_DUTY_BIT])
      begin
         next_ledGate = 1'b1; // RULE24
      end
      else
      begin
         next_ledGate = dimGate;
      end
      next_currentLevel = (driverOptions[OPT_DUTY_BIT] && !driverOptions[OPT_PASS_BIT])
         ? measuredDuty : dcCurrentLevel; // RULE21 RULE24

      // Read data
      statusByte = {2'b00, twoChannelsDownFlag, oneChannelDownFlag, backlightOnFlag,
         inputOvercurrentFlag, thermalTripFlag, faultSummary}; // RULE16 RULE17
      identityByte = {ID_MARK, MAKER_CODE, SILICON_REV}; // RULE18 RULE19 RULE20
      if (hostRead)
      begin
         unique case (hostAddr)
            ADDR_BRIGHTNESS: next_hostRdData = pwmBrightness; // RULE8
            ADDR_CONTROL: next_hostRdData = backlightControl; // RULE5
            ADDR_STATUS: next_hostRdData = statusByte;
            ADDR_IDENTITY: next_hostRdData = identityByte;
            ADDR_DC_LEVEL: next_hostRdData = dcCurrentLevel; // RULE21
            ADDR_OPTIONS: next_hostRdData = driverOptions;
            default: next_hostRdData = READ_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         backlightControl <= RESET_CONTROL;
         pwmBrightness <= RESET_BRIGHTNESS;
         dcCurrentLevel <= RESET_DC_LEVEL;
         driverOptions <= RESET_OPTIONS;
         faultSummary <= 1'b0;
         dimMode <= DIM_COMBINED;
         blState <= BL_OFF;
         onCount <= '0;
         pwmCount <= 8'h00;
         highCount <= 8'h00;
         measuredDuty <= 8'h00;
         hostRdData <= 8'h00;
         hostRdValid <= 1'b0;
         channelsActive <= CHANNEL_NONE;
         ledGate <= 1'b0;
         currentLevel <= RESET_DC_LEVEL;
      end
      else
      begin
         backlightControl <= next_backlightControl;
         pwmBrightness <= next_pwmBrightness;
         dcCurrentLevel <= next_dcCurrentLevel;
         driverOptions <= next_driverOptions;
         faultSummary <= next_faultSummary;
         dimMode <= next_dimMode;
         blState <= next_blState;
         onCount <= next_onCount;
         pwmCount <= next_pwmCount;
         highCount <= next_highCount;
         measuredDuty <= next_measuredDuty;
         hostRdData <= next_hostRdData;
         hostRdValid <= next_hostRdValid;
         channelsActive <= next_channelsActive;
         ledGate <= next_ledGate;
         currentLevel <= next_currentLevel;
      end
   end

   // ----------------------------------------
   // Option fields
   // ----------------------------------------
   assign dimmingMode = dimMode;
   assign switchDriveStrength = driverOptions[OPT_DRIVE_LSB+1:OPT_DRIVE_LSB]; // RULE25 RULE26
   assign switchFrequencySelect = driverOptions[OPT_FSW_BIT]; // RULE27
   assign shortThreshold = driverOptions[OPT_VSC_LSB+1:OPT_VSC_LSB]; // RULE28

endmodule // blc_regs

/* verification/blc_host_model.sv */
`timescale 1ns/10ps

module blc_host_model
   import blc_pkg::*;
(
   // Clock
   input wire logic clk,
   // Byte port
   output logic [7:0] hostAddr,
   output logic [7:0] hostWrData,
   output logic hostWrite,
   output logic hostRead,
   input wire logic [7:0] hostRdData,
   input wire logic hostRdValid
);
   // ----------------------------------------
   // Byte cycles, released lines inverted
   // ----------------------------------------
   initial
   begin
      hostAddr = 8'h00;
      hostWrData = 8'h00;
      hostWrite = 1'b0;
      hostRead = 1'b0;
   end

   task automatic drop();
      hostWrite = 1'b0;
      hostRead = 1'b0;
      hostAddr = ~hostAddr;
      hostWrData = ~hostWrData;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      hostAddr = a;
      hostWrData = d;
      hostWrite = 1'b1;
      @(posedge clk);
      #1;
      drop();
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk);
      #1;
      hostAddr = a;
      hostRead = 1'b1;
      @(posedge clk);
      #1;
      drop();
      ok = hostRdValid;
      d = hostRdData;
   endtask
endmodule // blc_host_model

/* verification/blc_regs_assertions.sv */
`timescale 1ns/10ps

module blc_regs_checker
   import blc_pkg::*;
#(
   parameter int unsigned ON_DELAY_CYCLES = BL_ON_MAX_CYCLES,
   parameter logic [3:0] MAKER_CODE = 4'hF,
   parameter logic [2:0] SILICON_REV = 3'h0
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [7:0] hostAddr,
   input wire logic [7:0] hostWrData,
   input wire logic hostWrite,
   input wire logic hostRead,
   input wire logic [7:0] hostRdData,
   input wire logic hostRdValid,
   // Pins
   input wire logic thermalTripPin,
   input wire logic inputOvercurrentPin,
   input wire logic [5:0] channelFaultPin,
   input wire logic pwmInputPin,
   // Driver controls
   input wire logic [5:0] channelsActive,
   input wire logic ledGate,
   input wire logic [7:0] currentLevel,
   input wire logic [1:0] dimmingMode,
   input wire logic [1:0] switchDriveStrength,
   input wire logic switchFrequencySelect,
   input wire logic [1:0] shortThreshold
);
   // ----------------------------------------
   // Start-up wait counter
   // ----------------------------------------
   localparam int ON_LIMIT = ON_DELAY_CYCLES + 2;
   logic ctlWr;
   logic [19:0] waitCount;
   logic [19:0] next_waitCount;
   assign ctlWr = hostWrite && hostAddr == ADDR_CONTROL;

   always_comb
   begin
      next_waitCount = 20'h00000;
      if (ctlWr && hostWrData[CTL_ON_BIT] && channelsActive == CHANNEL_NONE && waitCount == 20'h00000)
         next_waitCount = 20'h00001;
      else if (waitCount != 20'h00000 && channelsActive == CHANNEL_NONE && !(ctlWr && !hostWrData[CTL_ON_BIT]))
         next_waitCount = waitCount + 20'h00001;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         waitCount <= 20'h00000;
      else
         waitCount <= next_waitCount;
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   read_answer_a: assert property (hostRead |=> hostRdValid) else $error("read not answered");
   valid_cause_a: assert property (hostRdValid |-> $past(hostRead)) else $error("stray read valid");
   status_read_a: assert property (hostRead && hostAddr == ADDR_STATUS |=> hostRdData[7:6] == 2'b00
      && hostRdData[3] == ($past(channelsActive) == CHANNEL_MASK)) else $error("status read wrong");
   identity_read_a: assert property (hostRead && hostAddr == ADDR_IDENTITY
      |=> hostRdData == {ID_MARK, MAKER_CODE, SILICON_REV}) else $error("identity wrong");
   off_now_a: assert property (ctlWr && !hostWrData[CTL_ON_BIT]
      |=> channelsActive == CHANNEL_NONE && !ledGate) else $error("not off at once");
   on_bound_a: assert property (waitCount <= ON_LIMIT) else $error("start-up too slow");
   mode_set_a: assert property (ctlWr && hostWrData[0] && hostWrData[2:1] != 2'b11
      |=> dimmingMode == $past(hostWrData[2:1])) else $error("mode not taken");
   mode_keep_a: assert property (ctlWr && hostWrData[2:0] == 3'b111 |=> $stable(dimmingMode))
      else $error("mode not kept");
   option_fields_a: assert property (hostWrite && hostAddr == ADDR_OPTIONS
      |=> {switchDriveStrength, switchFrequencySelect, shortThreshold} == $past(hostWrData[4:0]))
      else $error("option outputs wrong");

   cover property (ctlWr && hostWrData[2:0] == 3'b111);
   cover property ($rose(channelsActive == CHANNEL_MASK));
   cover property (hostRead && hostAddr == ADDR_STATUS ##1 hostRdData[ST_FAULT_BIT]);
endmodule // blc_regs_checker

bind blc_regs blc_regs_checker #(.ON_DELAY_CYCLES(ON_DELAY_CYCLES), .MAKER_CODE(MAKER_CODE),
   .SILICON_REV(SILICON_REV)) i_blc_regs_checker (.clk(clk), .reset(reset), .hostAddr(hostAddr),
   .hostWrData(hostWrData), .hostWrite(hostWrite), .hostRead(hostRead), .hostRdData(hostRdData),
   .hostRdValid(hostRdValid), .thermalTripPin(thermalTripPin), .inputOvercurrentPin(inputOvercurrentPin),
   .channelFaultPin(channelFaultPin), .pwmInputPin(pwmInputPin), .channelsActive(channelsActive),
   .ledGate(ledGate), .currentLevel(currentLevel), .dimmingMode(dimmingMode),
   .switchDriveStrength(switchDriveStrength), .switchFrequencySelect(switchFrequencySelect),
   .shortThreshold(shortThreshold));

/* verification/testbench.sv */
`timescale 1ns/10ps
`define CHECK(g, e) \
   begin \
      comparisons++; \
      if ((g) !== (e)) \
      begin \
         fails++; \
         $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
      end \
   end

module testbench
   import blc_pkg::*;
;
   // ----------------------------------------
   // Design and host
   // ----------------------------------------
   localparam int ON_CYC = 20;
   logic clk, reset, hostWrite, hostRead, hostRdValid, thermalTripPin, inputOvercurrentPin, pwmInputPin;
   logic ledGate, switchFrequencySelect, ok;
   logic [7:0] hostAddr, hostWrData, hostRdData, currentLevel, rdv;
   logic [5:0] channelFaultPin, channelsActive;
   logic [1:0] dimmingMode, switchDriveStrength, shortThreshold;
   int fails = 0;
   int comparisons = 0;
   logic [7:0] ra[7] = '{ADDR_BRIGHTNESS, ADDR_CONTROL, ADDR_STATUS, ADDR_IDENTITY, ADDR_DC_LEVEL,
      ADDR_OPTIONS, 8'h05};
   logic [7:0] rv[7] = '{8'hFF, 8'h00, 8'h00, 8'hA8, 8'hFF, 8'h1F, 8'h00};
   logic [7:0] mw[4] = '{8'h03, 8'h07, 8'h05, 8'h01};
   logic [1:0] me[4] = '{2'b01, 2'b01, 2'b10, 2'b00};

   // Maker code value is arbitrary
   blc_regs #(.ON_DELAY_CYCLES(ON_CYC), .MAKER_CODE(4'h5), .SILICON_REV(3'h0)) i_blc_regs (.clk(clk),
      .reset(reset), .hostAddr(hostAddr), .hostWrData(hostWrData), .hostWrite(hostWrite), .hostRead(hostRead),
      .hostRdData(hostRdData), .hostRdValid(hostRdValid), .thermalTripPin(thermalTripPin),
      .inputOvercurrentPin(inputOvercurrentPin), .channelFaultPin(channelFaultPin), .pwmInputPin(pwmInputPin),
      .channelsActive(channelsActive), .ledGate(ledGate), .currentLevel(currentLevel), .dimmingMode(dimmingMode),
      .switchDriveStrength(switchDriveStrength), .switchFrequencySelect(switchFrequencySelect),
      .shortThreshold(shortThreshold));
   blc_host_model i_blc_host_model (.clk(clk), .hostAddr(hostAddr), .hostWrData(hostWrData),
      .hostWrite(hostWrite), .hostRead(hostRead), .hostRdData(hostRdData), .hostRdValid(hostRdValid));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_blc_host_model.wr(a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      i_blc_host_model.rd(a, rdv, ok);
      `CHECK(ok, 1'b1)
      `CHECK(rdv, e)
   endtask

   task automatic close_out();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      #100000;
      fails++;
      close_out();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      reset = 1'b1;
      {thermalTripPin, inputOvercurrentPin, pwmInputPin, channelFaultPin} = 9'h000;
      cyc(10);
      reset = 1'b0;
      for (int i = 0; i < 7; i++) rdc(ra[i], rv[i]);
      wr(ADDR_CONTROL, 8'hFA);
      rdc(ADDR_CONTROL, 8'hFA);
      wr(ADDR_CONTROL, 8'h00);
      rdc(ADDR_CONTROL, 8'h00);
      wr(ADDR_IDENTITY, 8'h00);
      rdc(ADDR_IDENTITY, 8'hA8);
      wr(ADDR_STATUS, 8'hFF);
      rdc(ADDR_STATUS, 8'h00);
      wr(ADDR_BRIGHTNESS, 8'h3C);
      wr(ADDR_DC_LEVEL, 8'h5A);
      rdc(ADDR_DC_LEVEL, 8'h5A);
      rdc(ADDR_BRIGHTNESS, 8'h3C);
      `CHECK(currentLevel, 8'h5A)
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_OPTIONS, {3'h0, i[1:0], i[0], i[1:0]});
         `CHECK({switchDriveStrength, switchFrequencySelect, shortThreshold}, {i[1:0], i[0], i[1:0]})
      end
      wr(ADDR_CONTROL, 8'h01);
      cyc(ON_CYC - 1);
      `CHECK(channelsActive, CHANNEL_NONE)
      cyc(1);
      `CHECK(channelsActive, CHANNEL_MASK)
      rdc(ADDR_STATUS, 8'h08);
      thermalTripPin = 1'b1;
      cyc(4);
      rdc(ADDR_STATUS, 8'h0B);
      thermalTripPin = 1'b0;
      cyc(4);
      rdc(ADDR_STATUS, 8'h09);
      wr(ADDR_STATUS, 8'h00);
      rdc(ADDR_STATUS, 8'h08);
      channelFaultPin = 6'h03;
      cyc(4);
      rdc(ADDR_STATUS, 8'h39);
      channelFaultPin = 6'h01;
      cyc(4);
      rdc(ADDR_STATUS, 8'h19);
      inputOvercurrentPin = 1'b1;
      cyc(4);
      wr(ADDR_STATUS, 8'h00);
      rdc(ADDR_STATUS, 8'h1D);
      {inputOvercurrentPin, channelFaultPin} = 7'h00;
      cyc(4);
      wr(ADDR_STATUS, 8'h00);
      rdc(ADDR_STATUS, 8'h08);
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_CONTROL, mw[i]);
         `CHECK(dimmingMode, me[i])
      end
      wr(ADDR_OPTIONS, 8'h5F);
      for (int i = 0; i < 2; i++)
      begin
         pwmInputPin = ~i[0];
         cyc(5);
         `CHECK(ledGate, ~i[0])
      end
      wr(ADDR_OPTIONS, 8'h3F);
      pwmInputPin = 1'b1;
      cyc(600);
      `CHECK({ledGate, currentLevel}, 9'h1FF)
      pwmInputPin = 1'b0;
      wr(ADDR_OPTIONS, 8'h1F);
      thermalTripPin = 1'b1;
      cyc(4);
      thermalTripPin = 1'b0;
      cyc(4);
      wr(ADDR_CONTROL, 8'h00);
      `CHECK({channelsActive, ledGate}, 7'h00)
      rdc(ADDR_STATUS, 8'h00);
      wr(ADDR_CONTROL, 8'h06);
      cyc(ON_CYC + 5);
      `CHECK(channelsActive, CHANNEL_NONE)
      thermalTripPin = 1'b1;
      wr(ADDR_CONTROL, 8'h01);
      wr(ADDR_CONTROL, 8'h00);
      cyc(ON_CYC + 5);
      rdc(ADDR_STATUS, 8'h02);
      thermalTripPin = 1'b0;
      close_out();
   end
endmodule // testbench
